/* hw/three_wire_serial_io_map.svh */
// Register map, field positions, reset values and clock counts of the serial channel.
// Assumes inclusion by bare name from any file that needs the constants.
`ifndef THREE_WIRE_SERIAL_IO_MAP_SVH
`define THREE_WIRE_SERIAL_IO_MAP_SVH

`define TW_MODE_ADDR   16'hff90
`define TW_SHIFT_ADDR  16'hff80
`define TW_MODE_RST    8'h00
`define TW_SHIFT_RST   8'h00
`define TW_EN_BIT      7
`define TW_XFER_BIT    2
`define TW_SEL_HI_BIT  1
`define TW_SEL_LO_BIT  0
`define TW_SEL_EXT     2'h0
`define TW_SEL_TMR     2'h1
`define TW_SEL_DIV8    2'h2
`define TW_SEL_DIV16   2'h3
`define TW_DIV8_RATIO  8
`define TW_DIV16_RATIO 16
`define TW_FRAME_BITS  8

`endif

/* hw/three_wire_serial_io_pkg.sv */
// Types shared by the serial channel modules.
// Assumes the constants header is on the include path.
`include "three_wire_serial_io_map.svh"

package three_wire_serial_io_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic        bit_op;
    logic [2:0]  bit_sel;
    logic [7:0]  wdata;
  } cpu_req_type;

  typedef struct packed {
    logic       enable;
    logic       rx_only;
    logic [1:0] clk_sel;
  } mode_reg_type;

  typedef enum logic {
    ST_IDLE,
    ST_SHIFT
  } xfer_state_type;

endpackage

/* hw/sync_2ff.sv */
// Two-stage synchroniser for pin levels.
// Assumes inputs are asynchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_i, // System clock
  input  wire logic             rst_i,  // Async reset, high
  input  wire logic [WIDTH-1:0] d_i,    // Asynchronous levels
  output logic      [WIDTH-1:0] q_o     // Synchronised levels
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '1;
      q_o    <= '1;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // sync_2ff

`default_nettype wire

/* hw/serial_clock_gen.sv */
// Serial clock source select, internal divider and edge detection.
// Assumes ext_lvl_i is already synchronised and tmr_lvl_i is on mclk_i.
`timescale 1ns/1ps
`default_nettype none

module serial_clock_gen
  import three_wire_serial_io_pkg::*;
#(
  parameter int CW = 4
) (
  input  wire logic       mclk_i,    // System clock
  input  wire logic       rst_i,     // Async reset, high
  input  wire logic [1:0] sel_i,     // Clock source select
  input  wire logic       run_i,     // Frame in progress
  input  wire logic       ext_lvl_i, // Synchronised external clock
  input  wire logic       tmr_lvl_i, // Timer two output level
  output logic            lvl_o,     // Selected clock level
  output logic            fall_o,    // Falling edge while running
  output logic            rise_o     // Rising edge while running
);
  logic [CW-1:0] div_cnt_r;
  logic [CW-1:0] half_cnt;
  logic          int_lvl_r;
  logic          prev_r;
  logic          internal;

  assign internal = sel_i[`TW_SEL_HI_BIT];
  assign half_cnt = sel_i[`TW_SEL_LO_BIT] ? CW'(`TW_DIV16_RATIO / 2) : CW'(`TW_DIV8_RATIO / 2);

  // Divider rests high so each frame opens with a falling edge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_r <= '0;
      int_lvl_r <= 1'b1;
    end else if (!run_i || !internal) begin
      div_cnt_r <= '0;
      int_lvl_r <= 1'b1;
    end else if (div_cnt_r == half_cnt - CW'(1)) begin
      div_cnt_r <= '0;
      int_lvl_r <= ~int_lvl_r;
    end else begin
      div_cnt_r <= div_cnt_r + CW'(1);
    end
  end

  always_comb begin
    unique case (sel_i)
      `TW_SEL_EXT: lvl_o = ext_lvl_i;
      `TW_SEL_TMR: lvl_o = tmr_lvl_i;
      default:     lvl_o = int_lvl_r;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= lvl_o;
    end
  end

  assign fall_o = run_i & prev_r & ~lvl_o;
  assign rise_o = run_i & ~prev_r & lvl_o;
endmodule // serial_clock_gen

`default_nettype wire

/* hw/three_wire_serial_io.sv */
// Three-wire clocked serial channel: mode register, shift register and pins.
// Assumes a CPU register port on mclk_i and pins driven through external buffers.
`timescale 1ns/1ps
`default_nettype none

module three_wire_serial_io
  import three_wire_serial_io_pkg::*;
(
  input  wire logic                          mclk_i,   // System clock
  input  wire logic                          rst_i,    // Async reset, high
  input  wire three_wire_serial_io_pkg::cpu_req_type cpu_i, // CPU access
  output logic [7:0]                         rdata_o,  // Read data
  output logic                               rvalid_o, // Read data valid
  input  wire logic                          tmr_lvl_i, // Timer two output
  input  wire logic                          sck_i,    // Clock pin level
  output logic                               sck_o,    // Clock pin drive
  output logic                               sck_oe_o, // Clock pin enable
  input  wire logic                          si_i,     // Serial in pin
  output logic                               so_o,     // Serial out pin
  output logic                               so_oe_o,  // Serial out enable
  output logic                               done_o,   // Transfer done pulse
  output logic                               busy_o    // Transfer running
);
  import three_wire_serial_io_pkg::*;

  mode_reg_type   mode_r;
  xfer_state_type state_r;
  logic [7:0]     shift_r;
  logic [3:0]     bit_cnt_r;
  logic           half_r;
  logic           so_latch_r;
  logic [1:0]     pin_sync;
  logic           ser_lvl;
  logic           fall;
  logic           rise;
  logic           hit_mode;
  logic           hit_shift;
  logic           trigger;
  logic           running;
  logic [7:0]     mode_byte;
  logic [7:0]     mode_nxt;

  assign hit_mode  = (cpu_i.addr == `TW_MODE_ADDR);
  assign hit_shift = (cpu_i.addr == `TW_SHIFT_ADDR);
  assign running   = (state_r == ST_SHIFT);

  // Only an access made while enable is already stored can start a frame
  assign trigger = mode_r.enable && !running && hit_shift &&
                   (mode_r.rx_only ? cpu_i.rd : cpu_i.wr);

  assign mode_byte = {mode_r.enable, 4'h0, mode_r.rx_only, mode_r.clk_sel};

  // Input pin is only sampled, never driven, so it stays usable as a port
  sync_2ff #(
    .WIDTH (2)
  ) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({sck_i, si_i}),
    .q_o    (pin_sync)
  );

  serial_clock_gen #(
    .CW (4)
  ) u_clk (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .sel_i     (mode_r.clk_sel),
    .run_i     (running),
    .ext_lvl_i (pin_sync[1]),
    .tmr_lvl_i (tmr_lvl_i),
    .lvl_o     (ser_lvl),
    .fall_o    (fall),
    .rise_o    (rise)
  );

  // Byte or single-bit write; reserved bits are dropped
  always_comb begin
    mode_nxt = mode_byte;
    if (cpu_i.bit_op) begin
      mode_nxt[cpu_i.bit_sel] = cpu_i.wdata[0];
    end else begin
      mode_nxt = cpu_i.wdata;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= mode_reg_type'(4'h0);
    end else if (cpu_i.wr && hit_mode) begin
      mode_r.enable  <= mode_nxt[`TW_EN_BIT];
      mode_r.rx_only <= mode_nxt[`TW_XFER_BIT];
      mode_r.clk_sel <= {mode_nxt[`TW_SEL_HI_BIT], mode_nxt[`TW_SEL_LO_BIT]};
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else if (!mode_r.enable) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (trigger) begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (rise && half_r && bit_cnt_r == 4'(`TW_FRAME_BITS - 1)) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Bit counter and phase: a rise counts only after its own fall
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_r <= 4'h0;
      half_r    <= 1'b0;
    end else if (!mode_r.enable || !running) begin
      bit_cnt_r <= 4'h0;
      half_r    <= 1'b0;
    end else if (fall) begin
      half_r <= 1'b1;
    end else if (rise && half_r) begin
      half_r    <= 1'b0;
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // Parallel load when idle; shift on fall, capture on rise
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_r <= `TW_SHIFT_RST;
    end else if (!running) begin
      if (cpu_i.wr && hit_shift) begin
        shift_r <= cpu_i.wdata;
      end
    end else if (fall) begin
      shift_r <= {shift_r[6:0], shift_r[0]};
    end else if (rise && half_r) begin
      shift_r[0] <= pin_sync[0];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      so_latch_r <= 1'b0;
    end else if (running && fall) begin
      so_latch_r <= shift_r[7];
    end
  end

  // Pin drivers; all released while the channel is stopped
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      so_o     <= 1'b0;
      so_oe_o  <= 1'b0;
      sck_o    <= 1'b1;
      sck_oe_o <= 1'b0;
    end else begin
      so_oe_o  <= mode_r.enable;
      sck_oe_o <= mode_r.enable && (mode_r.clk_sel != `TW_SEL_EXT);
      if (mode_r.rx_only) begin
        so_o <= 1'b0;
      end else if (running && fall) begin
        so_o <= shift_r[7];
      end else begin
        so_o <= so_latch_r;
      end
      // Pin clock follows counted edges only, so a free-running timer level
      // seen at frame start never shows the far side a spurious fall
      if (!running) begin
        sck_o <= 1'b1;
      end else if (fall) begin
        sck_o <= 1'b0;
      end else if (rise && half_r) begin
        sck_o <= ser_lvl;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= mode_r.enable && running && rise && half_r &&
                bit_cnt_r == 4'(`TW_FRAME_BITS - 1);
      busy_o <= running && !(rise && half_r && bit_cnt_r == 4'(`TW_FRAME_BITS - 1)) &&
                mode_r.enable;
    end
  end

  // Registered read port; unmapped addresses read zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= cpu_i.rd;
      if (cpu_i.rd && hit_mode) begin
        rdata_o <= mode_byte;
      end else if (cpu_i.rd && hit_shift) begin
        rdata_o <= shift_r;
      end else if (cpu_i.rd) begin
        rdata_o <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence start_seq;
    trigger ##1 running;
  endsequence

  sequence last_bit_seq;
    mode_r.enable && running && rise && half_r && bit_cnt_r == 4'h7;
  endsequence

  xfer_start_a: assert property (trigger |-> ##1 running)
    else $error("trigger access did not start a frame");
  late_enable_a: assert property (!running && !trigger |=> !running)
    else $error("frame started without an enabled trigger");
  rx_out_low_a: assert property (mode_r.rx_only |=> !so_o)
    else $error("receive-only output not held low");
  count_clear_a: assert property (!mode_r.enable |=> bit_cnt_r == 4'h0 && !busy_o)
    else $error("counter not cleared while stopped");
  pins_free_a: assert property (!mode_r.enable |=> !so_oe_o && !sck_oe_o)
    else $error("pins driven while stopped");
  frame_end_a: assert property (last_bit_seq |=> done_o && !running)
    else $error("frame did not end after eighth bit");
  msb_first_a: assert property (running && fall |=> shift_r[7:1] == $past(shift_r[6:0]))
    else $error("shift register did not move toward the MSB");
  shift_out_a: assert property (running && fall && !mode_r.rx_only |=>
                                so_o == $past(shift_r[7]))
    else $error("output bit is not the shifted MSB");
  capture_in_a: assert property (running && rise && half_r && !fall |=>
                                 shift_r[0] == $past(pin_sync[0]))
    else $error("input bit not captured on rise");
  clk_dir_a: assert property (mode_r.enable && mode_r.clk_sel != `TW_SEL_EXT |=> sck_oe_o)
    else $error("internal clock pin not driven");
  idle_high_a: assert property (!running |=> sck_o)
    else $error("serial clock not high while idle");
endmodule // three_wire_serial_io

`default_nettype wire

/* dv/serial_peer_model.sv */
// Peripheral chip on the far side of the three-wire serial channel.
// Assumes the bench resolves the clock wire and pulses load_i before each frame.
`timescale 1ns/1ps
`default_nettype none

module serial_peer_model #(
  parameter int HALF = 8
) (
  input  wire logic       mclk_i, // System clock
  input  wire logic       sck_i,  // Resolved clock wire
  input  wire logic       so_i,   // Device serial out
  input  wire logic       load_i, // Load reply, clear counts
  input  wire logic [7:0] tx_i,   // Reply byte
  input  wire logic       go_i,   // Start an external frame
  output logic            sck_o,  // Clock drive, high when idle
  output logic            si_o,   // Serial in drive
  output logic [7:0]      rx_o    // Byte taken from the device
);
  logic [7:0] sh_r;
  logic [3:0] n_r;

  initial begin
    sck_o = 1'b1;
    si_o  = 1'b0;
    rx_o  = 8'h00;
  end

  always @(posedge load_i) begin
    sh_r = tx_i;
    n_r  = 4'h0;
    rx_o = 8'h00;
  end

  // Next reply bit after each fall, MSB first
  always @(negedge sck_i) begin
    si_o = sh_r[7];
    sh_r = {sh_r[6:0], 1'b0};
  end

  always @(posedge sck_i) begin
    rx_o = {rx_o[6:0], so_i};
    n_r  = n_r + 4'h1;
    // Released line no longer shows the last bit, once the device has sampled it
    if (n_r == 4'h8) begin
      repeat (4) @(posedge mclk_i);
      si_o = ~si_o;
    end
  end

  // Half period of HALF cycles keeps the clock at or below system clock over 8
  always @(posedge go_i) begin
    repeat (8) begin
      repeat (HALF) @(posedge mclk_i);
      sck_o <= 1'b0;
      repeat (HALF) @(posedge mclk_i);
      sck_o <= 1'b1;
    end
  end
endmodule // serial_peer_model
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench of the three-wire serial channel.
// Assumes the design package and a peripheral model on the serial pins.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp, msg) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("wrong value at %0t: %s", $time, msg); \
    end \
  end

module testbench;
  import three_wire_serial_io_pkg::*;
  logic        mclk_i, rst_i, tmr_lvl_i, load, go, ext_en;
  logic        rvalid, sck_o, sck_oe, so, so_oe, done, busy, peer_sck, si;
  logic [7:0]  rdata, rx, tx, shadow;
  logic [2:0]  tcnt;
  cpu_req_type cpu;
  wire logic   sck_w;
  int          n_errors = 0;
  int          n_compared = 0;
  logic [7:0]  modes [5] = '{8'h82, 8'h83, 8'h81, 8'h80, 8'h86};
  logic [7:0]  txd [5] = '{8'ha5, 8'h01, 8'h80, 8'hc3, 8'h00};
  logic [7:0]  rxd [5] = '{8'h3c, 8'hfe, 8'h7f, 8'h96, 8'h5e};

  // Pull-up on the clock wire when nobody drives it
  assign sck_w = sck_oe ? sck_o : (ext_en ? peer_sck : 1'b1);

  three_wire_serial_io uut (
    .mclk_i(mclk_i), .rst_i(rst_i), .cpu_i(cpu), .rdata_o(rdata), .rvalid_o(rvalid),
    .tmr_lvl_i(tmr_lvl_i), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .done_o(done), .busy_o(busy)
  );

  serial_peer_model peer (
    .mclk_i(mclk_i), .sck_i(sck_w), .so_i(so), .load_i(load), .tx_i(tx), .go_i(go),
    .sck_o(peer_sck), .si_o(si), .rx_o(rx)
  );

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Timer two in toggle output, one level change every 8 cycles
  always @(posedge mclk_i) begin
    tcnt <= tcnt + 3'h1;
    if (tcnt == 3'h7) tmr_lvl_i <= ~tmr_lvl_i;
  end

  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic access(input logic [15:0] a, input logic w, input logic b,
                        input logic [2:0] s, input logic [7:0] d);
    @(posedge mclk_i);
    cpu <= '{addr: a, wr: w, rd: ~w, bit_op: b, bit_sel: s, wdata: d};
    @(posedge mclk_i);
    cpu <= '0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    access(a, 1'b1, 1'b0, 3'h0, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string m);
    access(a, 1'b0, 1'b0, 3'h0, 8'h00);
    @(negedge mclk_i);
    `CHECK(rvalid, 1'b1, m)
    `CHECK(rdata, e, m)
  endtask

  task automatic wait_done(input logic rxo);
    for (int i = 0; i < 400; i++) begin
      @(negedge mclk_i);
      if (rxo) `CHECK(so, 1'b0, "held output")
      if (done === 1'b1) break;
    end
    `CHECK(done, 1'b1, "frame end")
    repeat (2) @(negedge mclk_i);
    `CHECK({busy, sck_o}, 2'b01, "idle after frame")
  endtask

  // Shift register left alone until the frame ends
  task automatic frame(input logic [7:0] m, input logic [7:0] d, input logic [7:0] r);
    wr(16'hff90, m);
    ext_en <= (m[1:0] == 2'b00);
    tx <= r;
    load <= 1'b1;
    @(posedge mclk_i);
    load <= 1'b0;
    if (m[2]) rd(16'hff80, shadow, "rx trigger");
    else wr(16'hff80, d);
    repeat (2) @(negedge mclk_i);
    `CHECK(busy, 1'b1, "busy")
    `CHECK(sck_oe, m[1:0] != 2'b00, "clock drive")
    if (m[1:0] == 2'b00) begin
      @(posedge mclk_i);
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
    end
    wait_done(m[2]);
    `CHECK(rx, m[2] ? 8'h00 : d, "sent byte")
    rd(16'hff80, r, "received byte");
    shadow = r;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    finish_test();
  end

  initial begin
    cpu = '0;
    rst_i = 1'b1;
    tmr_lvl_i = 1'b0;
    tcnt = 3'h0;
    load = 1'b0;
    go = 1'b0;
    ext_en = 1'b0;
    tx = 8'h00;
    shadow = 8'h00;
    repeat (20) @(posedge mclk_i);
    `CHECK({sck_o, sck_oe, so_oe, busy}, 4'b1000, "reset pins")
    rst_i <= 1'b0;
    rd(16'hff90, 8'h00, "mode reset");
    rd(16'hff80, 8'h00, "shift reset");
    rd(16'h0000, 8'h00, "unmapped read");
    wr(16'hff90, 8'hff);
    rd(16'hff90, 8'h87, "reserved bits");
    wr(16'hff90, 8'h02);
    wr(16'hff80, 8'h5a);
    access(16'hff90, 1'b1, 1'b1, 3'h7, 8'h01);
    rd(16'hff90, 8'h82, "bit write");
    repeat (12) @(negedge mclk_i);
    `CHECK(busy, 1'b0, "late enable")
    rd(16'hff80, 8'h5a, "parallel load");
    shadow = 8'h5a;
    for (int k = 0; k < 5; k++) frame(modes[k], txd[k], rxd[k]);
    wr(16'hff90, 8'h83);
    wr(16'hff80, 8'hff);
    repeat (20) @(negedge mclk_i);
    wr(16'hff90, 8'h00);
    repeat (3) @(negedge mclk_i);
    `CHECK({busy, sck_oe, so_oe}, 3'b000, "abort")
    frame(8'h82, 8'h33, 8'hcc);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
